/* File: tbl_byte_access.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - bottom flag high whenever count equals zero
// - max flag high whenever count equals all ones
// - top chosen by mode: fixed 65535/255/511/1023, compare A or capture
// - one 8-bit holding byte shared by all four 16-bit registers
// - only low-byte accesses move a 16-bit value
// - low write loads holding byte and written byte in one cycle
// - count or capture low read returns low half and latches upper half into holding
// - compare reads bypass holding byte, leaving it unchanged
// - holding byte survives low writes for reuse
// - counter high location reaches the holding byte instead
// - processor count write beats clear and count in same cycle
module tbl_byte_access (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_cnt_clear,
  input wire logic i_cnt_step,
  input wire logic i_cnt_down,
  input wire logic [2:0] i_top_sel,
  input wire logic i_capture,
  output logic [15:0] o_timer_count_value,
  output logic [15:0] o_compare_value_a,
  output logic [15:0] o_compare_value_b,
  output logic [15:0] o_capture_value,
  output logic [15:0] o_top,
  output logic o_bottom,
  output logic o_max,
  output logic o_at_top
);
  logic [15:0] timer_count_value;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value;
  logic [15:0] next_count;
  logic [15:0] next_cmpa;
  logic [15:0] next_cmpb;
  logic [15:0] next_cap;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic [15:0] top;
  logic [15:0] next_top;
  logic bottom;
  logic next_bottom;
  logic max;
  logic next_max;
  logic at_top;
  logic next_at_top;
  logic [7:0] hold;

  tbl_bus_if bus ();
  assign bus.wr = i_wr;
  assign bus.rd = i_rd;
  assign bus.addr = i_addr;
  assign bus.wdata = i_wdata;

  tbl_hold_reg u_hold (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .bus(bus),
    .i_upper_cnt(timer_count_value[15:8]),
    .i_upper_cap(capture_value[15:8]),
    .o_hold(hold)
  );

  function automatic logic [15:0] top_of(input logic [2:0] sel,
      input logic [15:0] cmpa, input logic [15:0] cap);
    if (sel == tbl_pkg::TOPSEL_8BIT) begin
      top_of = tbl_pkg::TOP_8BIT;
    end else if (sel == tbl_pkg::TOPSEL_9BIT) begin
      top_of = tbl_pkg::TOP_9BIT;
    end else if (sel == tbl_pkg::TOPSEL_10BIT) begin
      top_of = tbl_pkg::TOP_10BIT;
    end else if (sel == tbl_pkg::TOPSEL_CMPA) begin
      top_of = cmpa;
    end else if (sel == tbl_pkg::TOPSEL_CAP) begin
      top_of = cap;
    end else begin
      top_of = tbl_pkg::CNT_MAX;
    end
  endfunction : top_of

  // registers
  always_comb begin
    next_count = timer_count_value;
    next_cmpa = compare_value_a;
    next_cmpb = compare_value_b;
    next_cap = capture_value;
    if (i_wr && i_addr == tbl_pkg::ADDR_CNT_LO) begin
      next_count = {hold, i_wdata};
    end else if (i_cnt_clear) begin
      next_count = tbl_pkg::CNT_BOTTOM;
    end else if (i_cnt_step && i_cnt_down) begin
      next_count = timer_count_value - 16'h0001;
    end else if (i_cnt_step) begin
      next_count = timer_count_value + 16'h0001;
    end
    if (i_wr && i_addr == tbl_pkg::ADDR_CMPA_LO) begin
      next_cmpa = {hold, i_wdata};
    end
    if (i_wr && i_addr == tbl_pkg::ADDR_CMPB_LO) begin
      next_cmpb = {hold, i_wdata};
    end
    if (i_wr && i_addr == tbl_pkg::ADDR_CAP_LO) begin
      next_cap = {hold, i_wdata};
    end else if (i_capture) begin
      next_cap = timer_count_value;
    end
  end

  // read path and status
  always_comb begin
    next_rvalid = i_rd;
    next_rdata = rdata;
    if (i_rd) begin
      if (i_addr == tbl_pkg::ADDR_CNT_LO) begin
        next_rdata = timer_count_value[7:0];
      end else if (i_addr == tbl_pkg::ADDR_CMPA_LO) begin
        next_rdata = compare_value_a[7:0];
      end else if (i_addr == tbl_pkg::ADDR_CMPA_HI) begin
        next_rdata = compare_value_a[15:8];
      end else if (i_addr == tbl_pkg::ADDR_CMPB_LO) begin
        next_rdata = compare_value_b[7:0];
      end else if (i_addr == tbl_pkg::ADDR_CMPB_HI) begin
        next_rdata = compare_value_b[15:8];
      end else if (i_addr == tbl_pkg::ADDR_CAP_LO) begin
        next_rdata = capture_value[7:0];
      end else begin
        next_rdata = hold;
      end
    end
    next_top = top_of(i_top_sel, next_cmpa, next_cap);
    next_bottom = next_count == tbl_pkg::CNT_BOTTOM;
    next_max = next_count == tbl_pkg::CNT_MAX;
    next_at_top = next_count == next_top;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_count_value <= tbl_pkg::REG_RESET;
      compare_value_a <= tbl_pkg::REG_RESET;
      compare_value_b <= tbl_pkg::REG_RESET;
      capture_value <= tbl_pkg::REG_RESET;
      rdata <= tbl_pkg::HOLD_RESET;
      rvalid <= 1'b0;
      top <= tbl_pkg::CNT_MAX;
      bottom <= 1'b1;
      max <= 1'b0;
      at_top <= 1'b0;
    end else begin
      timer_count_value <= next_count;
      compare_value_a <= next_cmpa;
      compare_value_b <= next_cmpb;
      capture_value <= next_cap;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      top <= next_top;
      bottom <= next_bottom;
      max <= next_max;
      at_top <= next_at_top;
    end
  end

  assign o_timer_count_value = timer_count_value;
  assign o_compare_value_a = compare_value_a;
  assign o_compare_value_b = compare_value_b;
  assign o_capture_value = capture_value;
  assign o_rdata = rdata;
  assign o_rvalid = rvalid;
  assign o_top = top;
  assign o_bottom = bottom;
  assign o_max = max;
  assign o_at_top = at_top;

  AST_BOTTOM_FLAG: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_bottom == (timer_count_value == 16'h0000))
    else $error("bottom flag wrong");
  AST_MAX_FLAG: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_max == (timer_count_value == 16'hffff))
    else $error("max flag wrong");
  AST_TOP_8BIT: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_top_sel == tbl_pkg::TOPSEL_8BIT |=> o_top == 16'h00ff)
    else $error("fixed top wrong");
  AST_CNT_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_wr && i_addr == tbl_pkg::ADDR_CNT_LO)
    |=> timer_count_value == {$past(hold), $past(i_wdata)})
    else $error("count write lost");
  AST_HI_WRITE_NO_MOVE: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) (i_wr && i_addr == tbl_pkg::ADDR_CMPB_HI
    && !i_rd) |=> $stable(compare_value_b))
    else $error("high write moved register");
  AST_CMPA_HI_READ: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) (i_rd && i_addr == tbl_pkg::ADDR_CMPA_HI)
    |=> o_rvalid && o_rdata == $past(compare_value_a[15:8]))
    else $error("compare high read wrong");
  AST_CNT_HI_READ: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) (i_rd && !i_wr && i_addr == tbl_pkg::ADDR_CNT_LO)
    ##1 (i_rd && !i_wr && i_addr == tbl_pkg::ADDR_CNT_HI)
    |=> o_rdata == $past(timer_count_value[15:8], 2))
    else $error("atomic count read wrong");
  AST_REUSE_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_wr && i_addr == tbl_pkg::ADDR_CMPA_LO) ##1
    (i_wr && i_addr == tbl_pkg::ADDR_CMPB_LO)
    |=> compare_value_b[15:8] == compare_value_a[15:8])
    else $error("holding byte reuse failed");

  COV_CNT_WRITE: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_wr && i_addr == tbl_pkg::ADDR_CNT_HI) ##1
    (i_wr && i_addr == tbl_pkg::ADDR_CNT_LO));
  COV_CNT_READ: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_rd && i_addr == tbl_pkg::ADDR_CNT_LO) ##1
    (i_rd && i_addr == tbl_pkg::ADDR_CNT_HI));
  COV_WRITE_BEATS_CLEAR: cover property (@(posedge i_clk_sys)
    disable iff (!i_nrst) i_wr && i_addr == tbl_pkg::ADDR_CNT_LO && i_cnt_clear);
  COV_MAX: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) o_max);
endmodule : tbl_byte_access
`default_nettype wire

/* File: tbl_pkg.sv */
package tbl_pkg;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  // byte addresses on the 8-bit bus, low byte even, high byte odd
  localparam logic [2:0] ADDR_CNT_LO = 3'h0;
  localparam logic [2:0] ADDR_CNT_HI = 3'h1;
  localparam logic [2:0] ADDR_CMPA_LO = 3'h2;
  localparam logic [2:0] ADDR_CMPA_HI = 3'h3;
  localparam logic [2:0] ADDR_CMPB_LO = 3'h4;
  localparam logic [2:0] ADDR_CMPB_HI = 3'h5;
  localparam logic [2:0] ADDR_CAP_LO = 3'h6;
  localparam logic [2:0] ADDR_CAP_HI = 3'h7;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // top selection codes
  localparam logic [2:0] TOPSEL_MAX = 3'h0;
  localparam logic [2:0] TOPSEL_8BIT = 3'h1;
  localparam logic [2:0] TOPSEL_9BIT = 3'h2;
  localparam logic [2:0] TOPSEL_10BIT = 3'h3;
  localparam logic [2:0] TOPSEL_CMPA = 3'h4;
  localparam logic [2:0] TOPSEL_CAP = 3'h5;
endpackage : tbl_pkg

/* File: tbl_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tbl_bus_if;
  logic wr;
  logic rd;
  logic [2:0] addr;
  logic [7:0] wdata;
  modport ctl(output wr, output rd, output addr, output wdata);
  modport hold(input wr, input rd, input addr, input wdata);
endinterface : tbl_bus_if
`default_nettype wire

/* File: tbl_hold_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module tbl_hold_reg (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  tbl_bus_if.hold bus,
  input wire logic [7:0] i_upper_cnt,
  input wire logic [7:0] i_upper_cap,
  output logic [7:0] o_hold
);
  logic [7:0] hold;
  logic [7:0] next_hold;

  always_comb begin
    next_hold = hold;
    if (bus.wr && bus.addr[0]) begin
      next_hold = bus.wdata;
    end else if (bus.rd && bus.addr == tbl_pkg::ADDR_CNT_LO) begin
      next_hold = i_upper_cnt;
    end else if (bus.rd && bus.addr == tbl_pkg::ADDR_CAP_LO) begin
      next_hold = i_upper_cap;
    end
    // compare reads and low writes leave it alone
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      hold <= tbl_pkg::HOLD_RESET;
    end else begin
      hold <= next_hold;
    end
  end

  assign o_hold = hold;

  AST_LOW_WRITE_KEEPS: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst) (bus.wr && !bus.addr[0]) |=> $stable(hold))
    else $error("holding byte changed on low write");
  AST_CMP_READ_KEEPS: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst)
    (bus.rd && !bus.wr && (bus.addr == tbl_pkg::ADDR_CMPA_LO ||
     bus.addr == tbl_pkg::ADDR_CMPB_LO)) |=> $stable(hold))
    else $error("compare read touched holding byte");
  AST_CNT_READ_LATCH: assert property (@(posedge i_clk_sys)
    disable iff (!i_nrst)
    (bus.rd && !bus.wr && bus.addr == tbl_pkg::ADDR_CNT_LO)
    |=> hold == $past(i_upper_cnt))
    else $error("counter upper byte not latched");
endmodule : tbl_hold_reg
`default_nettype wire

/* File: tbl_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tbl_cpu_model (
  input wire logic i_clk_sys,
  output logic o_wr,
  output logic o_rd,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 3'h0;
    o_wdata = 8'h00;
  end
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    // released bus shows no stale byte
    o_wdata = ~d;
  endtask : wr8
  task automatic rd8(input logic [2:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk_sys);
    o_rd = 1'b0;
    d = i_rdata;
  endtask : rd8
  // two bytes back to back, strobe held high between them
  task automatic wr2(input logic [2:0] a1, input logic [7:0] d1,
      input logic [2:0] a2, input logic [7:0] d2);
    @(negedge i_clk_sys);
    o_wr = 1'b1;
    o_addr = a1;
    o_wdata = d1;
    @(negedge i_clk_sys);
    o_addr = a2;
    o_wdata = d2;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_wdata = ~d2;
  endtask : wr2
  task automatic rd2(input logic [2:0] a1, input logic [2:0] a2,
      output logic [7:0] d1, output logic [7:0] d2);
    @(negedge i_clk_sys);
    o_rd = 1'b1;
    o_addr = a1;
    @(negedge i_clk_sys);
    d1 = i_rdata;
    o_addr = a2;
    @(negedge i_clk_sys);
    o_rd = 1'b0;
    d2 = i_rdata;
  endtask : rd2
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr2(a + 3'h1, v[15:8], a, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [2:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd2(a, a + 3'h1, lo, hi);
    v = {hi, lo};
  endtask : rd16
endmodule : tbl_cpu_model
`default_nettype wire

/* File: timer16_byte_access_latch_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module timer16_byte_access_latch_tb_top;
  logic clk, nrst, clr, step, down, cap, wr, rd, bot, mx, att, rv;
  logic [2:0] tsel, addr;
  logic [7:0] wdata, rdata, b;
  logic [15:0] cnt, ca, cb, capv, top, v;
  int err_count, n_compared;
  tbl_cpu_model cpu (.i_clk_sys(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata));
  tbl_byte_access dut (.i_clk_sys(clk), .i_nrst(nrst), .i_wr(wr),
    .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_rvalid(rv), .i_cnt_clear(clr), .i_cnt_step(step), .i_cnt_down(down),
    .i_top_sel(tsel), .i_capture(cap), .o_timer_count_value(cnt),
    .o_compare_value_a(ca), .o_compare_value_b(cb), .o_capture_value(capv),
    .o_top(top), .o_bottom(bot), .o_max(mx), .o_at_top(att));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic t_reset;
    chk("bottom", 16'h0001, {15'h0000, bot});
    chk("max", 16'h0000, {15'h0000, mx});
    chk("top", tbl_pkg::CNT_MAX, top);
    chk("rvalid", 16'h0000, {15'h0000, rv});
    $display("reset test done");
  endtask : t_reset
  task automatic t_count;
    cpu.wr8(tbl_pkg::ADDR_CNT_HI, 8'h01);
    chk("count", 16'h0000, cnt);
    cpu.wr8(tbl_pkg::ADDR_CNT_LO, 8'hff);
    chk("count", 16'h01ff, cnt);
    cpu.rd16(tbl_pkg::ADDR_CNT_LO, v);
    chk("count read", 16'h01ff, v);
    cpu.wr16(tbl_pkg::ADDR_CNT_LO, 16'hffff);
    chk("max", 16'h0001, {15'h0000, mx});
    cpu.wr16(tbl_pkg::ADDR_CNT_LO, 16'h0000);
    chk("bottom", 16'h0001, {15'h0000, bot});
    $display("count test done");
  endtask : t_count
  task automatic t_reuse;
    cpu.wr8(tbl_pkg::ADDR_CMPA_HI, 8'h12);
    cpu.wr2(tbl_pkg::ADDR_CMPA_LO, 8'h34, tbl_pkg::ADDR_CMPB_LO, 8'h56);
    cpu.wr8(tbl_pkg::ADDR_CAP_LO, 8'h78);
    chk("cmp a", 16'h1234, ca);
    chk("cmp b", 16'h1256, cb);
    chk("capture", 16'h1278, capv);
    cpu.wr8(tbl_pkg::ADDR_CMPB_HI, 8'h9a);
    chk("cmp b", 16'h1256, cb);
    $display("reuse test done");
  endtask : t_reuse
  task automatic t_bypass;
    cpu.wr16(tbl_pkg::ADDR_CNT_LO, 16'hab01);
    cpu.rd8(tbl_pkg::ADDR_CNT_LO, b);
    cpu.rd16(tbl_pkg::ADDR_CMPA_LO, v);
    chk("cmp a read", 16'h1234, v);
    cpu.rd8(tbl_pkg::ADDR_CNT_HI, b);
    chk("rvalid", 16'h0001, {15'h0000, rv});
    chk("holding", 16'h00ab, {8'h00, b});
    cpu.rd16(tbl_pkg::ADDR_CAP_LO, v);
    chk("capture read", 16'h1278, v);
    $display("bypass test done");
  endtask : t_bypass
  task automatic t_top;
    logic [15:0] e [8];
    e = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff, 16'h1234, 16'h1278,
      16'hffff, 16'hffff};
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      tsel = 3'(i);
      @(negedge clk);
      chk("top", e[i], top);
    end
    tsel = tbl_pkg::TOPSEL_10BIT;
    cpu.wr16(tbl_pkg::ADDR_CNT_LO, 16'h03ff);
    chk("at top", 16'h0001, {15'h0000, att});
    $display("top test done");
  endtask : t_top
  task automatic t_prio;
    @(negedge clk);
    clr = 1'b1;
    step = 1'b1;
    cap = 1'b1;
    cpu.wr8(tbl_pkg::ADDR_CNT_HI, 8'h55);
    cpu.wr8(tbl_pkg::ADDR_CNT_LO, 8'h66);
    chk("count", 16'h5566, cnt);
    clr = 1'b0;
    cpu.wr8(tbl_pkg::ADDR_CAP_LO, 8'h77);
    chk("capture", 16'h5577, capv);
    step = 1'b0;
    cap = 1'b0;
    $display("priority test done");
  endtask : t_prio
  task automatic t_down;
    cpu.wr16(tbl_pkg::ADDR_CNT_LO, 16'h0001);
    @(negedge clk);
    step = 1'b1;
    down = 1'b1;
    @(negedge clk);
    chk("count", 16'h0000, cnt);
    chk("bottom", 16'h0001, {15'h0000, bot});
    @(negedge clk);
    step = 1'b0;
    down = 1'b0;
    chk("count", tbl_pkg::CNT_MAX, cnt);
    chk("max", 16'h0001, {15'h0000, mx});
    $display("down test done");
  endtask : t_down
  initial begin
    {nrst, clr, step, down, cap} = 5'h00;
    tsel = tbl_pkg::TOPSEL_MAX;
    err_count = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_count();
    t_reuse();
    t_bypass();
    t_top();
    t_prio();
    t_down();
    test_done();
  end
  initial begin
    #20000;
    err_count++;
    test_done();
  end
endmodule : timer16_byte_access_latch_tb_top
`default_nettype wire
